// >>> src/dfl_top.sv
`timescale 1ns/1ps
module dfl_top
   import dfl_pkg::*;
(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output      logic              hreadyout,
   output      logic              hresp,
   output      logic [31:0]       hrdata,
   input  wire logic              wraparound_select_n,
   input  wire logic              port_a_select_n,
   input  wire logic              port_a_direction,
   input  wire logic              port_a_enable,
   input  wire logic [DATA_W-1:0] port_a_data_in,
   output      logic [DATA_W-1:0] port_a_data_out,
   output      logic              port_a_data_oe,
   input  wire logic              port_b_select_n,
   input  wire logic              port_b_read_enable,
   output      logic [DATA_W-1:0] port_b_data_out,
   output      logic              port_b_data_oe,
   input  wire logic              port_c_write_enable,
   input  wire logic [DATA_W-1:0] port_c_data_in,
   output      logic              fifo1_empty_outready,
   output      logic              fifo1_nearly_empty_n,
   output      logic              fifo1_full_inready,
   output      logic              fifo1_nearly_full_n,
   output      logic              fifo2_empty_outready,
   output      logic              fifo2_nearly_empty_n,
   output      logic              fifo2_full_inready,
   output      logic              fifo2_nearly_full_n
);

   logic              first_word_fall_through_reg;
   logic [CNT_W-1:0]  fifo1_empty_offset_reg;
   logic [CNT_W-1:0]  fifo1_full_offset_reg;
   logic [CNT_W-1:0]  fifo2_empty_offset_reg;
   logic [CNT_W-1:0]  fifo2_full_offset_reg;
   logic              wr_phase_reg;
   logic [7:0]        wr_addr_reg;
   logic [31:0]       rdata_reg;

   logic              wr_req   [2];
   logic              rd_req   [2];
   logic [DATA_W-1:0] wr_data  [2];
   logic [DATA_W-1:0] out_data [2];
   logic [DATA_W-1:0] head     [2];
   logic              loading  [2];
   logic              room     [2];
   logic              outready [2];
   logic [CNT_W-1:0]  rd_level [2];
   logic [CNT_W-1:0]  x_ofs    [2];
   logic [CNT_W-1:0]  y_ofs    [2];
   logic              ef_or    [2];
   logic              ae_n     [2];
   logic              ff_ir    [2];
   logic              af_n     [2];

   // Port A decoding and the loopback path.
   wire a_cycle      = !port_a_select_n && port_a_enable;
   wire loop_on      = !wraparound_select_n && a_cycle;
   wire a_norm_write = a_cycle && wraparound_select_n && port_a_direction;
   wire a_norm_read  = a_cycle && wraparound_select_n && !port_a_direction;
   wire fifo2_word   = first_word_fall_through_reg ? outready[1] : (rd_level[1] != '0);
   wire loop_write   = loop_on && room[0];
   wire loop_read    = loop_on && fifo2_word && (room[0] || !port_a_direction);
   wire [DATA_W-1:0] loop_data = (!first_word_fall_through_reg && loading[1]) ? head[1] : out_data[1];

   assign wr_req[0]  = a_norm_write || loop_write;
   assign wr_data[0] = loop_on ? loop_data : port_a_data_in;
   assign rd_req[0]  = !port_b_select_n && port_b_read_enable;
   assign wr_req[1]  = port_c_write_enable;
   assign wr_data[1] = port_c_data_in;
   assign rd_req[1]  = a_norm_read || loop_read;

   assign x_ofs[0] = fifo1_empty_offset_reg;
   assign y_ofs[0] = fifo1_full_offset_reg;
   assign x_ofs[1] = fifo2_empty_offset_reg;
   assign y_ofs[1] = fifo2_full_offset_reg;

   for (genvar f = 0; f < 2; f++) begin : g_fifo
      logic [DATA_W-1:0] mem [DEPTH];
      logic [CNT_W-1:0]  wptr_reg;
      logic [CNT_W-1:0]  rptr_reg;
      logic [CNT_W-1:0]  wsync1_reg;
      logic [CNT_W-1:0]  wsync2_reg;
      logic [CNT_W-1:0]  rsync1_reg;
      logic [CNT_W-1:0]  rsync2_reg;
      logic [DATA_W-1:0] out_reg;
      logic              or_reg;
      logic              or_next;

      // Levels seen by each side come from two-stage pointer pipelines.
      wire [CNT_W-1:0] rlev  = wsync2_reg - rptr_reg;
      wire [CNT_W-1:0] wlev  = wptr_reg - rsync2_reg;
      wire             full  = wlev == DEPTH_WORDS;
      wire             have  = rlev != '0;
      wire             do_wr = wr_req[f] && !full;
      wire             do_ld = have && (first_word_fall_through_reg ? (!or_reg || rd_req[f]) : rd_req[f]);

      assign or_next = do_ld ? 1'b1 : (rd_req[f] ? 1'b0 : or_reg);

      always_ff @(posedge hclk) begin
         if (do_wr) begin
            mem[wptr_reg[ADDR_W-1:0]] <= wr_data[f];
         end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            wptr_reg   <= '0;
            rptr_reg   <= '0;
            wsync1_reg <= '0;
            wsync2_reg <= '0;
            rsync1_reg <= '0;
            rsync2_reg <= '0;
            out_reg    <= '0;
            or_reg     <= 1'b0;
         end else begin
            wptr_reg   <= do_wr ? wptr_reg + 12'h001 : wptr_reg;
            rptr_reg   <= do_ld ? rptr_reg + 12'h001 : rptr_reg;
            wsync1_reg <= wptr_reg;
            wsync2_reg <= wsync1_reg;
            rsync1_reg <= rptr_reg;
            rsync2_reg <= rsync1_reg;
            out_reg    <= do_ld ? mem[rptr_reg[ADDR_W-1:0]] : out_reg;
            or_reg     <= first_word_fall_through_reg && or_next;
         end
      end

      assign head[f]     = mem[rptr_reg[ADDR_W-1:0]];
      assign loading[f]  = do_ld;
      assign room[f]     = !full;
      assign outready[f] = or_reg;
      assign out_data[f] = out_reg;
      assign rd_level[f] = rlev;
      assign ef_or[f]    = first_word_fall_through_reg ? or_reg : have;
      assign ae_n[f]     = rlev > x_ofs[f];
      assign ff_ir[f]    = !full;
      assign af_n[f]     = wlev < (DEPTH_WORDS - y_ofs[f]);
   end

   // Flags leave on the port that owns them.
   assign fifo1_empty_outready = ef_or[0];
   assign fifo1_nearly_empty_n = ae_n[0];
   assign fifo1_full_inready   = ff_ir[0];
   assign fifo1_nearly_full_n  = af_n[0];
   assign fifo2_empty_outready = ef_or[1];
   assign fifo2_nearly_empty_n = ae_n[1];
   assign fifo2_full_inready   = ff_ir[1];
   assign fifo2_nearly_full_n  = af_n[1];

   assign port_a_data_out = out_data[1];
   assign port_a_data_oe  = !port_a_select_n && !port_a_direction;
   assign port_b_data_out = out_data[0];
   assign port_b_data_oe  = !port_b_select_n;

   // Register access over the bus, zero wait states.
   wire        addr_ok  = hsel && hready && htrans[1];
   wire [7:0]  rsel     = haddr[7:0];
   wire        do_write = wr_phase_reg;
   wire [31:0] status_w = {24'h000000, ef_or[1], ae_n[1], ff_ir[1], af_n[1],
                           ef_or[0], ae_n[0], ff_ir[0], af_n[0]};
   wire [31:0] rd_mux   = (rsel == OFS_CTRL)   ? {31'h00000000, first_word_fall_through_reg} :
                          (rsel == OFS_X1)     ? {20'h00000, fifo1_empty_offset_reg} :
                          (rsel == OFS_Y1)     ? {20'h00000, fifo1_full_offset_reg} :
                          (rsel == OFS_X2)     ? {20'h00000, fifo2_empty_offset_reg} :
                          (rsel == OFS_Y2)     ? {20'h00000, fifo2_full_offset_reg} :
                          (rsel == OFS_STATUS) ? status_w :
                          (rsel == OFS_LEVEL1) ? {20'h00000, rd_level[0]} :
                          (rsel == OFS_LEVEL2) ? {20'h00000, rd_level[1]} : 32'h00000000;
   wire [CNT_W-1:0] wval = hwdata[CNT_W-1:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_phase_reg <= 1'b0;
         wr_addr_reg  <= 8'h00;
         rdata_reg    <= 32'h00000000;
      end else begin
         wr_phase_reg <= addr_ok && hwrite;
         wr_addr_reg  <= rsel;
         rdata_reg    <= (addr_ok && !hwrite && haddr[31:8] == 24'h000000) ? rd_mux : 32'h00000000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_word_fall_through_reg               <= FIRST_WORD_FALL_THROUGH_RST;
         fifo1_empty_offset_reg <= OFFSET_RST;
         fifo1_full_offset_reg  <= OFFSET_RST;
         fifo2_empty_offset_reg <= OFFSET_RST;
         fifo2_full_offset_reg  <= OFFSET_RST;
      end else if (do_write) begin
         first_word_fall_through_reg               <= (wr_addr_reg == OFS_CTRL) ? hwdata[FIRST_WORD_FALL_THROUGH_BIT] : first_word_fall_through_reg;
         fifo1_empty_offset_reg <= (wr_addr_reg == OFS_X1) ? wval : fifo1_empty_offset_reg;
         fifo1_full_offset_reg  <= (wr_addr_reg == OFS_Y1) ? wval : fifo1_full_offset_reg;
         fifo2_empty_offset_reg <= (wr_addr_reg == OFS_X2) ? wval : fifo2_empty_offset_reg;
         fifo2_full_offset_reg  <= (wr_addr_reg == OFS_Y2) ? wval : fifo2_full_offset_reg;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_reg;

endmodule

// >>> src/dfl_pkg.sv
// Summary of operation
// - Driving the wraparound select low while port A is selected and enabled routes FIFO2 output data into FIFO1.
// - Loopback with port A writing stores FIFO2 output into FIFO1, port lines undriven.
// - Loopback with port A reading stores FIFO2 output into FIFO1 and drives port A.
// - With wraparound select high, port A does ordinary reads and writes only.
// - Loopback writes into FIFO1 need only FIFO1 room; loopback reads of FIFO2 need FIFO2 data, plus FIFO1 room when port A is writing.
// - Once FIFO1 is full, FIFO2 reads appear only on port A, and only when reading.
// - When FIFO2 empties in loopback, its last word keeps entering FIFO1 until full.
// - Flag changes caused by the other port pass two pointer flip-flop stages before the owning port sees them.
// - Each flag is produced in the clock domain of the port that shows it.
// - FIFO1 flags follow fill level against depth and offsets X1 and Y1.
// - FIFO2 flags follow the same thresholds with offsets X2 and Y2.
// - A word held in the output register is not counted as a memory word.
// - A word moved from memory to the output register frees its location.
// - Fall-through output-ready low keeps the previous word and ignores reads.
// - Standard empty flag low keeps the previous word and ignores reads.
// - The read pointer advances whenever a new word enters the output register.
// - Fall-through: new word and output-ready rise together at the third read edge.
// - Standard: the empty flag rises at the second read edge after the write.
// - An edge too close after a write is not counted as a synchronization cycle.
// - Dual flags show ready functions in fall-through mode, empty or full otherwise.
// - Standard mode loads the output register only on a selected read.
// - While full or input-ready is low, writes to that FIFO are ignored.
package dfl_pkg;
   localparam int                DATA_W      = 36;
   localparam int                DEPTH       = 2048;
   localparam int                ADDR_W      = 11;
   localparam int                CNT_W       = 12;
   localparam logic [CNT_W-1:0]  DEPTH_WORDS = 12'h800;
   localparam logic [CNT_W-1:0]  OFFSET_RST  = 12'h008;
   localparam logic              FIRST_WORD_FALL_THROUGH_RST    = 1'b0;
   localparam int                FIRST_WORD_FALL_THROUGH_BIT    = 0;
   localparam logic [7:0]        OFS_CTRL    = 8'h00;
   localparam logic [7:0]        OFS_X1      = 8'h04;
   localparam logic [7:0]        OFS_Y1      = 8'h08;
   localparam logic [7:0]        OFS_X2      = 8'h0c;
   localparam logic [7:0]        OFS_Y2      = 8'h10;
   localparam logic [7:0]        OFS_STATUS  = 8'h14;
   localparam logic [7:0]        OFS_LEVEL1  = 8'h18;
   localparam logic [7:0]        OFS_LEVEL2  = 8'h1c;
   localparam logic [1:0]        HTRANS_NSEQ = 2'h2;
endpackage

// >>> bench/dfl_chk.sv
`timescale 1ns/1ps
module dfl_chk
   import dfl_pkg::*;
(
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic              wraparound_select_n,
   input wire logic              port_a_select_n,
   input wire logic              port_a_direction,
   input wire logic              port_a_enable,
   input wire logic              port_a_data_oe,
   input wire logic              port_b_select_n,
   input wire logic              port_b_data_oe,
   input wire logic              port_c_write_enable,
   input wire logic [DATA_W-1:0] port_a_data_out,
   input wire logic [DATA_W-1:0] port_b_data_out,
   input wire logic              fifo1_empty_outready,
   input wire logic              fifo1_full_inready,
   input wire logic              fifo1_nearly_full_n,
   input wire logic              fifo2_empty_outready,
   input wire logic              fifo2_full_inready,
   input wire logic              fifo2_nearly_full_n
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire fifo1_write_try = !port_a_select_n && port_a_enable && (port_a_direction || !wraparound_select_n);
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready and okay");
   a_a_drive: assert property (port_a_data_oe == (!port_a_select_n && !port_a_direction))
      else $error("port a drive enable wrong");
   a_b_drive: assert property (port_b_data_oe == !port_b_select_n) else $error("port b drive enable wrong");
   a_reset_flags: assert property ($rose(hresetn) |-> !fifo1_empty_outready && !fifo2_empty_outready
      && fifo1_full_inready && fifo2_full_inready) else $error("flags wrong after reset");
   a_fifo2_fill: assert property ($rose(fifo2_empty_outready) |->
      $past(port_c_write_enable, 3) || $past(port_c_write_enable, 4)) else $error("fifo2 flag rose early");
   a_fifo1_fill: assert property ($rose(fifo1_empty_outready) |->
      $past(fifo1_write_try, 3) || $past(fifo1_write_try, 4)) else $error("fifo1 flag rose early");
   a_hold_b_out: assert property (!fifo1_empty_outready ##1 !fifo1_empty_outready |->
      $stable(port_b_data_out)) else $error("port b word changed while empty");
   a_hold_a_out: assert property (!fifo2_empty_outready ##1 !fifo2_empty_outready |->
      $stable(port_a_data_out)) else $error("port a word changed while empty");
   a_full_near1: assert property (!fifo1_full_inready |-> !fifo1_nearly_full_n) else $error("fifo1 near full");
   a_full_near2: assert property (!fifo2_full_inready |-> !fifo2_nearly_full_n) else $error("fifo2 near full");
   a_full_cause1: assert property ($fell(fifo1_full_inready) |-> $past(fifo1_write_try))
      else $error("fifo1 full without write");
   a_full_cause2: assert property ($fell(fifo2_full_inready) |-> $past(port_c_write_enable))
      else $error("fifo2 full without write");
endmodule
bind dfl_top dfl_chk dfl_chk_i (.*);

// >>> bench/dfl_port_c.sv
`timescale 1ns/1ps
module dfl_port_c
   import dfl_pkg::*;
(
   input  wire logic              hclk,
   output      logic              port_c_write_enable = 1'b0,
   output      logic [DATA_W-1:0] port_c_data_in = 36'h0
);
   // One word per call; the data lines show the inverse once the strobe drops.
   task automatic put(input logic [DATA_W-1:0] w);
      @(posedge hclk);
      port_c_write_enable <= 1'b1;
      port_c_data_in <= w;
      @(posedge hclk);
      port_c_write_enable <= 1'b0;
      port_c_data_in <= ~w;
   endtask
endmodule

// >>> bench/dfl_top_tb.sv
`timescale 1ns/1ps
module dfl_top_tb;
   import dfl_pkg::*;
   logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [1:0]        htrans = 2'h0;
   logic [2:0]        hsize = 3'h2;
   logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic              hreadyout, hresp, port_a_data_oe, port_b_data_oe, port_c_write_enable;
   logic              wraparound_select_n = 1'b1, port_a_select_n = 1'b1;
   logic              port_a_direction = 1'b0, port_a_enable = 1'b0;
   logic              port_b_select_n = 1'b1, port_b_read_enable = 1'b0;
   logic [DATA_W-1:0] port_a_data_in = 36'h0, port_a_data_out, port_b_data_out, port_c_data_in;
   logic              fifo1_empty_outready, fifo1_nearly_empty_n, fifo1_full_inready, fifo1_nearly_full_n;
   logic              fifo2_empty_outready, fifo2_nearly_empty_n, fifo2_full_inready, fifo2_nearly_full_n;
   int                failures = 0, checks = 0;
   dfl_top dfl_top_i (.*);
   dfl_port_c dfl_port_c_i (.*);
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   task automatic stop_test();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wait_rdy();
      int n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         stop_test();
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NSEQ;
      hwrite <= wr;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic pa(input logic lp_n, input logic sel_n, input logic dir, input logic en);
      @(posedge hclk);
      wraparound_select_n <= lp_n;
      port_a_select_n <= sel_n;
      port_a_direction <= dir;
      port_a_enable <= en;
   endtask
   task automatic t_std();
      dfl_port_c_i.put(36'h123456789);
      repeat (2) begin
         @(posedge hclk);
         check(fifo2_empty_outready, 1'b0);
      end
      @(posedge hclk);
      check(fifo2_empty_outready, 1'b1);
      check(port_a_data_out, 36'h0);
      pa(1'b1, 1'b0, 1'b0, 1'b1);
      pa(1'b1, 1'b0, 1'b0, 1'b0);
      @(posedge hclk);
      check(port_a_data_out, 36'h123456789);
      check(fifo2_empty_outready, 1'b0);
      pa(1'b1, 1'b1, 1'b0, 1'b0);
      $display("t_std done");
   endtask
   task automatic t_loop();
      logic [DATA_W-1:0] exp [4] = '{36'ha1, 36'hb2, 36'hb2, 36'hb2};
      dfl_port_c_i.put(36'ha1);
      dfl_port_c_i.put(36'hb2);
      repeat (4) @(posedge hclk);
      pa(1'b0, 1'b0, 1'b0, 1'b1);
      repeat (3) @(posedge hclk);
      pa(1'b1, 1'b1, 1'b0, 1'b0);
      repeat (3) @(posedge hclk);
      check(port_a_data_out, 36'hb2);
      port_b_select_n <= 1'b0;
      port_b_read_enable <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         @(posedge hclk);
         if (i > 0) check(port_b_data_out, exp[i-1]);
         if (i == 3) port_b_read_enable <= 1'b0;
      end
      check(fifo1_empty_outready, 1'b0);
      port_b_select_n <= 1'b1;
      $display("t_loop done");
   endtask
   task automatic t_full();
      int n = 0;
      logic [31:0] r;
      dfl_port_c_i.put(36'hc3);
      repeat (3) @(posedge hclk);
      pa(1'b0, 1'b0, 1'b1, 1'b1);
      do begin
         @(posedge hclk);
         n++;
      end while (fifo1_full_inready !== 1'b0 && n < 2200);
      check(n, DEPTH + 1);
      check({port_a_data_oe, fifo1_nearly_full_n, fifo1_nearly_empty_n, fifo1_empty_outready}, 4'h3);
      pa(1'b1, 1'b1, 1'b0, 1'b0);
      ahb(1'b0, OFS_LEVEL1, 32'h0, r);
      check(r, DEPTH_WORDS);
      ahb(1'b0, OFS_STATUS, 32'h0, r);
      check(r, 36'h3c);
      $display("t_full done");
   endtask
   task automatic t_first_word_fall_through();
      logic [31:0] r;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({fifo1_empty_outready, fifo1_nearly_empty_n, fifo1_full_inready, fifo1_nearly_full_n,
             fifo2_empty_outready, fifo2_nearly_empty_n, fifo2_full_inready, fifo2_nearly_full_n}, 8'h33);
      ahb(1'b1, OFS_CTRL, 32'h1, r);
      ahb(1'b1, OFS_X2, 32'h0, r);
      ahb(1'b0, OFS_CTRL, 32'h0, r);
      check(r, 36'h1);
      ahb(1'b0, OFS_X1, 32'h0, r);
      check(r, OFFSET_RST);
      ahb(1'b0, 8'h40, 32'h0, r);
      check(r, 36'h0);
      dfl_port_c_i.put(36'h5a5a5a5a5);
      repeat (3) begin
         @(posedge hclk);
         check(fifo2_empty_outready, 1'b0);
      end
      @(posedge hclk);
      check(fifo2_empty_outready, 1'b1);
      check(port_a_data_out, 36'h5a5a5a5a5);
      check(fifo2_nearly_empty_n, 1'b0);
      $display("t_first_word_fall_through done");
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({fifo1_empty_outready, fifo1_nearly_empty_n, fifo1_full_inready, fifo1_nearly_full_n,
             fifo2_empty_outready, fifo2_nearly_empty_n, fifo2_full_inready, fifo2_nearly_full_n}, 8'h33);
      t_std();
      t_loop();
      t_full();
      t_first_word_fall_through();
      stop_test();
   end
endmodule
